// ### rtl/aimux_select.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - four columns: input select holds four 2-bit pin fields, one per column.
// - four columns: edge columns use one 4-to-1 mux, inner ones choose of two.
// - columns 1 and 2 have extra selectors driven by buffer control bits.
// - buffer control bit 7 set routes column 0 mux output into column 1.
// - buffer control bit 6 set routes column 3 mux output into column 2.
// - bits 5..2 enable amplifiers of columns 1, 2, 0, 3 respectively.
// - bit 1 puts every output driver in bypass, input straight to output.
// - bit 0 set gives high driver power, clear gives low power.
// - two columns: only the low two select fields exist, rest reserved.
// - two columns: select fields pick among even and odd pins, eight total.
// - two columns reserve bits 6,4,2; one column reserves 6,4,3,2 and keeps 7,5,1,0.
// - input select register exists only with four or two columns.
module aimux_select #(
   parameter int NUM_COLUMNS = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEnable,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output aimux_pkg::aimux_ctrl_type ctrlOut,
   output aimux_pkg::aimux_route_type routeOut
);
   import aimux_pkg::*;

   // ==========================================================
   // implemented bits per column count
   localparam logic [7:0] IN_MASK = (NUM_COLUMNS == 4) ? AIMUX_IN_MASK_4COL :
      (NUM_COLUMNS == 2) ? AIMUX_IN_MASK_2COL : AIMUX_IN_MASK_1COL;
   localparam logic [7:0] BUF_MASK = (NUM_COLUMNS == 4) ? AIMUX_BUF_MASK_4COL :
      (NUM_COLUMNS == 2) ? AIMUX_BUF_MASK_2COL : AIMUX_BUF_MASK_1COL;

   logic [7:0] inSel_q;
   logic [7:0] bufCtrl_q;
   logic awHeld_q;
   logic [9:0] awAddr_q;
   logic wHeld_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic rValid_q;
   logic [31:0] rData_q;
   logic [1:0] rResp_q;
   logic writeFire;
   logic writeHitIn;
   logic writeHitBuf;
   logic readHitIn;
   logic readHitBuf;
   logic [9:0] rdAddr;

   // ==========================================================
   // axi write path: address and data taken in either order
   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign writeFire = awHeld_q && wHeld_q && !bValid_q;
   // wide ports so an unmapped address never aliases onto a register
   assign writeHitIn = (awAddr_q == AIMUX_IN_SEL_ADDR) && (NUM_COLUMNS != 1);
   assign writeHitBuf = (awAddr_q == AIMUX_BUF_CTRL_ADDR);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 10'h000;
      end else if (clkEnable) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr[9:0] | {9'h000, |s_axi_awaddr[11:10]};
         end else if (writeFire) begin
            awHeld_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else if (clkEnable) begin
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end else if (writeFire) begin
            wHeld_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bValid_q <= 1'b0;
         bResp_q <= AIMUX_RESP_OKAY;
      end else if (clkEnable) begin
         if (writeFire) begin
            bValid_q <= 1'b1;
            bResp_q <= (writeHitIn || writeHitBuf) ? AIMUX_RESP_OKAY : AIMUX_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // registers: only implemented bits store, reserved stay zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inSel_q <= AIMUX_IN_SEL_RESET;
      end else if (clkEnable && writeFire && writeHitIn && wStrb_q[0]) begin
         inSel_q <= wData_q[7:0] & IN_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bufCtrl_q <= AIMUX_BUF_CTRL_RESET;
      end else if (clkEnable && writeFire && writeHitBuf && wStrb_q[0]) begin
         bufCtrl_q <= wData_q[7:0] & BUF_MASK;
      end
   end

   // ==========================================================
   // axi read path
   assign s_axi_arready = !rValid_q;
   assign rdAddr = s_axi_araddr[9:0] | {9'h000, |s_axi_araddr[11:10]};
   assign readHitIn = (rdAddr == AIMUX_IN_SEL_ADDR) && (NUM_COLUMNS != 1);
   assign readHitBuf = (rdAddr == AIMUX_BUF_CTRL_ADDR);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= AIMUX_RESP_OKAY;
      end else if (clkEnable) begin
         if (s_axi_arvalid && !rValid_q) begin
            rValid_q <= 1'b1;
            rData_q <= readHitIn ? {24'h000000, inSel_q} :
               readHitBuf ? {24'h000000, bufCtrl_q} : 32'h0000_0000;
            rResp_q <= (readHitIn || readHitBuf) ? AIMUX_RESP_OKAY : AIMUX_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   // ==========================================================
   // control outputs straight from register bits
   assign ctrlOut.col0PinSelect = inSel_q[1:0];
   assign ctrlOut.col1PinSelect = inSel_q[3:2];
   assign ctrlOut.col2PinSelect = inSel_q[5:4];
   assign ctrlOut.col3PinSelect = inSel_q[7:6];
   assign ctrlOut.col1SourceSwap = bufCtrl_q[AIMUX_COL1_SWAP_BIT];
   assign ctrlOut.col2SourceSwap = bufCtrl_q[AIMUX_COL2_SWAP_BIT];
   assign ctrlOut.col1AmpEnable = bufCtrl_q[AIMUX_COL1_AMP_BIT];
   assign ctrlOut.col2AmpEnable = bufCtrl_q[AIMUX_COL2_AMP_BIT];
   assign ctrlOut.col0AmpEnable = bufCtrl_q[AIMUX_COL0_AMP_BIT];
   assign ctrlOut.col3AmpEnable = bufCtrl_q[AIMUX_COL3_AMP_BIT];
   assign ctrlOut.driverBypass = bufCtrl_q[AIMUX_BYPASS_BIT];
   assign ctrlOut.driverHighPower = bufCtrl_q[AIMUX_POWER_BIT];

   // ==========================================================
   // one-hot switch selects per column; each 4-to-1 mux decodes a field
   function automatic logic [3:0] decode4(input logic [1:0] sel);
      decode4 = 4'h1 << sel;
   endfunction

   // inner columns take a neighbour's mux output when swapped; edges have one
   always_comb begin
      routeOut.col0Source = decode4(inSel_q[1:0]);
      routeOut.col3Source = decode4(inSel_q[7:6]);
      routeOut.col1Source = bufCtrl_q[AIMUX_COL1_SWAP_BIT] ? decode4(inSel_q[1:0]) :
         decode4(inSel_q[3:2]);
      routeOut.col2Source = bufCtrl_q[AIMUX_COL2_SWAP_BIT] ? decode4(inSel_q[7:6]) :
         decode4(inSel_q[5:4]);
   end
endmodule // aimux_select

// ### rtl/aimux_pkg.sv
package aimux_pkg;
   // ==========================================================
   // register map (printed offset not a multiple of four: index)
   localparam logic [7:0] AIMUX_BUF_CTRL_IDX = 8'h62;
   localparam logic [7:0] AIMUX_IN_SEL_IDX = 8'h63;
   localparam logic [9:0] AIMUX_BUF_CTRL_ADDR = {AIMUX_BUF_CTRL_IDX, 2'b00};
   localparam logic [9:0] AIMUX_IN_SEL_ADDR = {AIMUX_IN_SEL_IDX, 2'b00};
   localparam logic [7:0] AIMUX_IN_SEL_RESET = 8'h00;
   localparam logic [7:0] AIMUX_BUF_CTRL_RESET = 8'h00;
   // ==========================================================
   // field positions
   localparam int AIMUX_COL1_SWAP_BIT = 7;
   localparam int AIMUX_COL2_SWAP_BIT = 6;
   localparam int AIMUX_COL1_AMP_BIT = 5;
   localparam int AIMUX_COL2_AMP_BIT = 4;
   localparam int AIMUX_COL0_AMP_BIT = 3;
   localparam int AIMUX_COL3_AMP_BIT = 2;
   localparam int AIMUX_BYPASS_BIT = 1;
   localparam int AIMUX_POWER_BIT = 0;
   // implemented-bit masks per column count
   localparam logic [7:0] AIMUX_IN_MASK_4COL = 8'hFF;
   localparam logic [7:0] AIMUX_IN_MASK_2COL = 8'h0F;
   localparam logic [7:0] AIMUX_IN_MASK_1COL = 8'h00;
   localparam logic [7:0] AIMUX_BUF_MASK_4COL = 8'hFF;
   localparam logic [7:0] AIMUX_BUF_MASK_2COL = 8'hAB;
   localparam logic [7:0] AIMUX_BUF_MASK_1COL = 8'hA3;
   // ==========================================================
   // axi response codes
   localparam logic [1:0] AIMUX_RESP_OKAY = 2'h0;
   localparam logic [1:0] AIMUX_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] col3PinSelect;
      logic [1:0] col2PinSelect;
      logic [1:0] col1PinSelect;
      logic [1:0] col0PinSelect;
      logic col1SourceSwap;
      logic col2SourceSwap;
      logic col0AmpEnable;
      logic col1AmpEnable;
      logic col2AmpEnable;
      logic col3AmpEnable;
      logic driverBypass;
      logic driverHighPower;
   } aimux_ctrl_type;

   typedef struct packed {
      logic [3:0] col0Source;
      logic [3:0] col1Source;
      logic [3:0] col2Source;
      logic [3:0] col3Source;
   } aimux_route_type;
endpackage

// ### verification/aimux_select_props.sv
`timescale 1ns/1ps
module aimux_select_props #(
   parameter int NUM_COLUMNS = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire aimux_pkg::aimux_ctrl_type ctrlOut,
   input wire aimux_pkg::aimux_route_type routeOut
);
   import aimux_pkg::*;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ==========================================
   // reset and bus
   reset_clears_a: assert property (
      $fell(rst) |-> ctrlOut == '0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset left state");
   read_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
   rdata_upper_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
   // a reset release also changes the fields, so that edge is excluded
   write_updates_a: assert property (
      $changed(ctrlOut) && !$past(rst) |-> $rose(s_axi_bvalid)) else $error("field moved without write");
   // ==========================================
   // routing
   col0_route_a: assert property (
      routeOut.col0Source == 4'h1 << ctrlOut.col0PinSelect) else $error("column 0 route");
   col3_route_a: assert property (
      routeOut.col3Source == 4'h1 << ctrlOut.col3PinSelect) else $error("column 3 route");
   col1_swap_a: assert property (
      routeOut.col1Source == 4'h1 << (ctrlOut.col1SourceSwap ? ctrlOut.col0PinSelect
      : ctrlOut.col1PinSelect)) else $error("column 1 route");
   col2_swap_a: assert property (
      routeOut.col2Source == 4'h1 << (ctrlOut.col2SourceSwap ? ctrlOut.col3PinSelect
      : ctrlOut.col2PinSelect)) else $error("column 2 route");
   narrow_fields_a: assert property (
      NUM_COLUMNS < 4 |-> ctrlOut[15:12] == 4'h0 && !ctrlOut.col2SourceSwap
      && !ctrlOut.col2AmpEnable && !ctrlOut.col3AmpEnable) else $error("reserved field set");
   one_column_a: assert property (
      NUM_COLUMNS == 1 |-> ctrlOut[15:8] == 8'h00 && !ctrlOut.col0AmpEnable) else $error("one col field");
endmodule // aimux_select_props
bind aimux_select aimux_select_props #(.NUM_COLUMNS(NUM_COLUMNS)) props (
   .ref_clk(ref_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ctrlOut(ctrlOut), .routeOut(routeOut));

// ### verification/aimux_testbench.sv
`timescale 1ns/1ps
module testbench;
   import aimux_pkg::*;
   // ==========================================
   // one bus feeds four, two and one column parts
   localparam int NCOL [3] = '{4, 2, 1};
   localparam logic [7:0] INM [3] = '{8'hFF, 8'h0F, 8'h00};
   localparam logic [7:0] BFM [3] = '{8'hFF, 8'hAB, 8'hA3};
   localparam logic [11:0] BUF_A = {2'b00, AIMUX_BUF_CTRL_ADDR};
   localparam logic [11:0] IN_A = {2'b00, AIMUX_IN_SEL_ADDR};
   localparam logic [11:0] ODD_A [2] = '{12'h190, 12'hD88};
   localparam logic [15:0] ROWS [5] = '{16'hE400, 16'h1BC0, 16'h4E3C, 16'hB183, 16'hFF42};
   logic ref_clk, rst, clkEn, awValid, wValid, arValid, rReady;
   logic [11:0] awAddr, arAddr;
   logic [3:0] wStrb;
   logic [7:0] wData;
   logic [2:0] awReady, wReady, bValid, arReady, rValid;
   logic [1:0] bResp [3], rResp [3], bSeen [3];
   logic [31:0] rData [3];
   logic [33:0] got [2][3];
   aimux_ctrl_type ctrl [3];
   aimux_route_type route [3];
   int badCount = 0, checkCount = 0, cyc = 0;
   for (genvar g = 0; g < 3; g++) begin : gen_dut
      aimux_select #(.NUM_COLUMNS(NCOL[g])) DUT (
         .ref_clk(ref_clk), .rst(rst), .clkEnable(clkEn), .s_axi_awaddr(awAddr),
         .s_axi_awvalid(awValid), .s_axi_awready(awReady[g]),
         // reserved bits of each part written as zero
         .s_axi_wdata({24'h0, wData & (awAddr == IN_A ? INM[g] : BFM[g])}),
         .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady[g]),
         .s_axi_bresp(bResp[g]), .s_axi_bvalid(bValid[g]), .s_axi_bready(1'b1),
         .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady[g]),
         .s_axi_rdata(rData[g]), .s_axi_rresp(rResp[g]), .s_axi_rvalid(rValid[g]),
         .s_axi_rready(rReady), .ctrlOut(ctrl[g]), .routeOut(route[g]));
   end
   // ==========================================
   // tasks
   function automatic logic [31:0] want(input logic [7:0] s, input logic [7:0] b);
      return {s, b[7], b[6], b[3], b[5], b[4], b[2], b[1], b[0], 4'h1 << s[1:0],
         4'h1 << (b[7] ? s[1:0] : s[3:2]), 4'h1 << (b[6] ? s[7:6] : s[5:4]), 4'h1 << s[7:6]};
   endfunction
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
      checkCount++;
      if (g !== e) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awReady[0]) awValid <= 1'b0;
         if (wReady[0]) wValid <= 1'b0;
      end while ((awValid && !awReady[0]) || (wValid && !wReady[0]));
      do @(posedge ref_clk); while (!bValid[0]);
      foreach (bSeen[i]) bSeen[i] = bResp[i];
   endtask
   // every read stalls rready one cycle, so held data gets watched
   task automatic rd(input logic [11:0] a, input int k);
      arAddr <= a;
      arValid <= 1'b1;
      do @(posedge ref_clk); while (!arReady[0]);
      arValid <= 1'b0;
      do @(posedge ref_clk); while (!rValid[0]);
      rReady <= 1'b1;
      @(posedge ref_clk);
      rReady <= 1'b0;
      foreach (got[k][i]) got[k][i] = {rResp[i], rData[i]};
   endtask
   task automatic check_all(input logic [7:0] s, input logic [7:0] b);
      rd(BUF_A, 0);
      rd(IN_A, 1);
      for (int i = 0; i < 3; i++) begin
         chk("route", want(s & INM[i], b & BFM[i]), {ctrl[i], route[i]});
         chk("buf read", {AIMUX_RESP_OKAY, 24'h0, b & BFM[i]}, got[0][i]);
         chk("in read", {i == 2 ? AIMUX_RESP_SLVERR : AIMUX_RESP_OKAY, 24'h0, s & INM[i]}, got[1][i]);
      end
   endtask
   task automatic report_and_stop();
      if (badCount == 0 && checkCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // clock, timeout and sequence
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         badCount++;
         report_and_stop();
      end
   end
   initial begin
      {rst, clkEn, awValid, wValid, arValid, rReady, wStrb} = {6'h30, 4'hF};
      {awAddr, arAddr, wData} = '0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      check_all(8'h00, 8'h00);
      foreach (ROWS[k]) begin
         wr(BUF_A, ROWS[k][7:0]);
         wr(IN_A, ROWS[k][15:8]);
         for (int i = 0; i < 3; i++) chk("bresp", i == 2 ? 2'h2 : 2'h0, bSeen[i]);
         check_all(ROWS[k][15:8], ROWS[k][7:0]);
      end
      foreach (ODD_A[k]) begin
         wr(ODD_A[k], 8'h00);
         chk("odd bresp", AIMUX_RESP_SLVERR, bSeen[0]);
         rd(ODD_A[k], 0);
         chk("odd read", {AIMUX_RESP_SLVERR, 32'h0}, got[0][0]);
      end
      // low byte strobe off: the write is accepted but must not land
      wStrb <= 4'h0;
      wr(BUF_A, 8'h00);
      wStrb <= 4'hF;
      // clock enable low: a pending write must neither answer nor land
      clkEn <= 1'b0;
      awAddr <= BUF_A;
      wData <= 8'h00;
      awValid <= 1'b1;
      wValid <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("frozen bvalid", 36'h0, {33'h0, bValid});
      chk("frozen ctrl", want(8'hFF, 8'h42), {ctrl[0], route[0]});
      clkEn <= 1'b1;
      wr(BUF_A, 8'h42);
      chk("thaw bresp", AIMUX_RESP_OKAY, bSeen[0]);
      check_all(8'hFF, 8'h42);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      check_all(8'h00, 8'h00);
      report_and_stop();
   end
endmodule // testbench
